// ===== common/osf_pkg.sv
// Constants and carrier types for the octal switch fault logic
// What this block does
// R1: Open-load-off fault is evaluated only while the output is commanded off.
// R2: Each output has its own open-load comparator; low voltage means open load.
// R3: Each detection current source follows its serial enable bit.
// R4: After power-on reset all detection current sources are off.
// R5: Logic supply loss or sleep input forces every detection source off.
// R6: Open-load reporting waits a filter delay between 100 and 300 us.
// R7: Chip select rising edge starts the timer; sample only after expiry.
// R8: A detected open-load fault stays latched until the controller reads it.
// R9: Thermal limit turns off only that output; others keep their state.
// R10: Thermally shut output retries automatically until cleared or commanded off.
// R11: Short and over-current faults report regardless of detection enable bits.
// R12: Under-voltage on logic or load supply turns all outputs off at once.
// R13: On supply recovery the logic returns to its power-on state.
// R14: Command bits 0-7 switch outputs on; bits 8-15 enable detection sources.
// R15: Status bits 8-15 read zero; bits 0-7 show latched faults.
// R16: With detection current disabled, open-load-off fault reads zero.
// R17: Only frames of 16 plus a multiple of 8 clocks are accepted.
// R18: A latched fault clears after readout if absent at the next sample.
// R19: A chip select rising edge during the filter restarts the timer.
package osf_pkg;
  localparam int OSF_CH       = 8;
  localparam int OSF_WORD     = 16;
  localparam int OSF_CNT_W    = 8;
  localparam int OSF_TMR_W    = 15;
  localparam int OSF_ON_LSB   = 0;
  localparam int OSF_DET_LSB  = 8;
  localparam int OSF_STEP_W   = 3;
  localparam logic [7:0] OSF_MIN_CLKS  = 8'h10;
  localparam logic [7:0] OSF_WORD_CNT  = 8'h10;
  localparam logic [7:0] OSF_STATUS_HI = 8'h00;
  localparam logic [7:0] OSF_ALL_OFF   = 8'h00;
  localparam logic [2:0] OSF_STEP_ZERO = 3'h0;
  // Filter delay in microseconds and clock rate
  localparam int OSF_FILT_MIN_US = 100;
  localparam int OSF_FILT_MAX_US = 300;
  localparam int OSF_FILT_US     = 200;
  localparam int OSF_CLK_MHZ     = 100;
  localparam int OSF_FILT_MIN_CYC = OSF_FILT_MIN_US * OSF_CLK_MHZ;
  localparam int OSF_FILT_MAX_CYC = OSF_FILT_MAX_US * OSF_CLK_MHZ;
  localparam int OSF_FILT_CYC     = OSF_FILT_US * OSF_CLK_MHZ;

  typedef struct packed {
    logic [OSF_CH-1:0] thermLim;
    logic [OSF_CH-1:0] overCur;
    logic [OSF_CH-1:0] openLoad;
  } osf_sense_s;

  typedef struct packed {
    logic logicUv;
    logic loadUv;
    logic sleepEn;
  } osf_supply_s;

  typedef struct packed {
    logic                 rst1;
    logic                 rst2;
    logic [OSF_CNT_W-1:0] cnt;
    logic [OSF_WORD:0]    shift;
    logic                 doBit;
  } osf_link_s;

  typedef struct packed {
    logic                 csSync1;
    logic                 csSync2;
    logic                 csPrev;
    osf_sense_s           sense1;
    osf_sense_s           sense2;
    osf_supply_s          sup1;
    osf_supply_s          sup2;
    logic [OSF_CNT_W-1:0] lastEnd;
    logic [OSF_CH-1:0]    cmdOn;
    logic [OSF_CH-1:0]    detEn;
    logic [OSF_CH-1:0]    faultLatch;
    logic                 readDone;
    logic                 tmrRun;
    logic [OSF_TMR_W-1:0] tmr;
    logic [OSF_WORD-1:0]  statusWord;
    logic [OSF_CH-1:0]    outDrive;
    logic [OSF_CH-1:0]    detSrc;
  } osf_core_s;
endpackage

// ===== rtl/osf_fault_logic.sv
// Fault filter, latch, protection shutdown and serial link of the switch
`timescale 1ns/100ps
module osf_fault_logic
  import osf_pkg::*;
#(
  parameter int FILT_CYCLES = OSF_FILT_CYC
) (
  // System clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Serial link pins
  input  wire logic              sclk,
  input  wire logic              csN,
  input  wire logic              mosi,
  output logic                   doPin,
  // Per-output sense pins and supply monitors
  input  wire osf_sense_s        sense,
  input  wire osf_supply_s       supply,
  // Output gate drive and detection current sources
  output logic [OSF_CH-1:0]      outDrive,
  output logic [OSF_CH-1:0]      detSrcEn
);

  localparam logic [OSF_TMR_W-1:0] TMR_LAST = OSF_TMR_W'(FILT_CYCLES - 1);

  osf_core_s q;
  osf_core_s next_q;
  osf_link_s l;
  osf_link_s next_l;

  logic                 csRise;
  logic                 sleeping;
  logic                 frameOk;
  logic                 expire;
  logic [OSF_CNT_W-1:0] frameLen;
  logic [OSF_CH-1:0]    shortNow;
  logic [OSF_CH-1:0]    olNow;
  logic [OSF_CH-1:0]    clearMask;
  logic [OSF_CNT_W-1:0] linkPos;
  logic [OSF_CNT_W-1:0] bitIdx;

  // Frame end seen through the synchronised chip select
  assign csRise   = q.csSync2 & ~q.csPrev;
  // R5 sleep or supply loss
  assign sleeping = ~q.sup2.sleepEn | q.sup2.logicUv | q.sup2.loadUv;
  assign frameLen = l.cnt - q.lastEnd;
  // R17 length check
  assign frameOk  = csRise && (frameLen >= OSF_MIN_CLKS)
                    && (frameLen[OSF_STEP_W-1:0] == OSF_STEP_ZERO);
  assign expire   = q.tmrRun && (q.tmr == TMR_LAST) && !csRise;
  // R11 shorts reported regardless of detection enables
  assign shortNow = q.sense2.thermLim | q.sense2.overCur;
  // R1 R2 R16 open load only when off and source enabled
  assign olNow    = q.sense2.openLoad & ~q.cmdOn & q.detEn;
  // R18 clear read bits whose fault has gone
  assign clearMask = (expire && q.readDone) ? ~(olNow | shortNow)
                                            : OSF_ALL_OFF;

  always_comb begin
    next_q = q;
    next_q.csSync1 = csN;
    next_q.csSync2 = q.csSync1;
    next_q.csPrev  = q.csSync2;
    next_q.sense1  = sense;
    next_q.sense2  = q.sense1;
    next_q.sup1    = supply;
    next_q.sup2    = q.sup1;
    // R7 R19 every frame end restarts the filter
    if (csRise) begin
      next_q.lastEnd = l.cnt;
      next_q.tmrRun  = 1'b1;
      next_q.tmr     = '0;
    end else if (q.tmrRun) begin
      next_q.tmr = q.tmr + 1'b1;
      if (expire) begin
        next_q.tmrRun = 1'b0;
      end
    end
    // R14 command word taken at a good frame end
    if (frameOk) begin
      next_q.cmdOn    = l.shift[OSF_ON_LSB +: OSF_CH];
      next_q.detEn    = l.shift[OSF_DET_LSB +: OSF_CH];
      next_q.readDone = 1'b1;
    end else if (expire) begin
      next_q.readDone = 1'b0;
    end
    // R8 latch holds; set wins over clear
    next_q.faultLatch = (q.faultLatch & ~clearMask) | shortNow
                        | (expire ? olNow : OSF_ALL_OFF);
    // R15 status frozen while a frame runs
    if (q.csSync2) begin
      next_q.statusWord = {OSF_STATUS_HI, q.faultLatch};
    end
    // R9 R10 thermal cut per output, retries when cooled
    next_q.outDrive = q.cmdOn & ~q.sense2.thermLim;
    // R3 sources follow their enable bits
    next_q.detSrc   = q.detEn;
    // R4 R12 R13 supply loss holds power-on state
    if (sleeping) begin
      next_q.cmdOn      = OSF_ALL_OFF;
      next_q.detEn      = OSF_ALL_OFF;
      next_q.faultLatch = OSF_ALL_OFF;
      next_q.readDone   = 1'b0;
      next_q.tmrRun     = 1'b0;
      next_q.tmr        = '0;
      next_q.statusWord = '0;
      next_q.outDrive   = OSF_ALL_OFF;
      next_q.detSrc     = OSF_ALL_OFF;
    end
    // R4 R13 power-on state; chip select flops reset to the idle level so
    // that no false frame end follows reset
    if (sys_rst) begin
      next_q         = '0;
      next_q.csSync1 = 1'b1;
      next_q.csSync2 = 1'b1;
      next_q.csPrev  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= next_q;
  end

  // Link side: position counts from the frame start held in the core
  assign linkPos = l.cnt + 8'h01 - q.lastEnd;
  assign bitIdx  = OSF_WORD_CNT - linkPos;

  always_comb begin
    next_l       = l;
    next_l.rst1  = sys_rst;
    next_l.rst2  = l.rst1;
    next_l.cnt   = l.cnt + 1'b1;
    next_l.shift = {l.shift[OSF_WORD-1:0], mosi};
    if ((linkPos != '0) && (linkPos <= OSF_WORD_CNT)) begin
      next_l.doBit = q.statusWord[bitIdx[3:0]];
    end else begin
      next_l.doBit = next_l.shift[OSF_WORD];
    end
    if (l.rst2) begin
      next_l.cnt   = '0;
      next_l.shift = '0;
      next_l.doBit = 1'b0;
    end
  end

  always_ff @(posedge sclk) begin
    l <= next_l;
  end

  assign doPin    = l.doBit;
  assign outDrive = q.outDrive;
  assign detSrcEn = q.detSrc;

  // Helper: cycles since the last frame end, saturating
  logic [OSF_TMR_W:0] sinceRise;
  always_ff @(posedge clk) begin
    if (sys_rst || csRise) begin
      sinceRise <= '0;
    end else if (!(&sinceRise)) begin
      sinceRise <= sinceRise + 1'b1;
    end
  end

  statusHi_zero_a: assert property ( // R15
    @(posedge clk) disable iff (sys_rst)
    q.statusWord[OSF_WORD-1:OSF_CH] == OSF_STATUS_HI)
    else $error("status upper byte not zero");

  sleep_src_off_a: assert property ( // R5
    @(posedge clk) disable iff (sys_rst)
    sleeping |=> (q.detSrc == OSF_ALL_OFF) && (q.detEn == OSF_ALL_OFF))
    else $error("detection source on while asleep");

  uv_out_off_a: assert property ( // R12
    @(posedge clk) disable iff (sys_rst)
    (q.sup2.logicUv || q.sup2.loadUv) |=> (q.outDrive == OSF_ALL_OFF))
    else $error("output on under supply fault");

  therm_per_out_a: assert property ( // R9
    @(posedge clk) disable iff (sys_rst)
    !sleeping |=> q.outDrive == ($past(q.cmdOn)
                                 & ~$past(q.sense2.thermLim)))
    else $error("thermal cut wrong output set");

  filter_window_a: assert property ( // R6
    @(posedge clk) disable iff (sys_rst)
    expire |-> (sinceRise >= (OSF_FILT_MIN_CYC - 1))
               && (sinceRise <= OSF_FILT_MAX_CYC))
    else $error("filter expiry outside window");

  restart_tmr_a: assert property ( // R19
    @(posedge clk) disable iff (sys_rst)
    (csRise && !sleeping) |=> q.tmrRun && (q.tmr == '0) ##1 !expire)
    else $error("timer not restarted at frame end");

  det_load_a: assert property ( // R14
    @(posedge clk) disable iff (sys_rst)
    (frameOk && !sleeping) |=>
      (q.detEn == $past(l.shift[OSF_DET_LSB +: OSF_CH]))
      && (q.cmdOn == $past(l.shift[OSF_ON_LSB +: OSF_CH])))
    else $error("command word not loaded");

  bad_len_a: assert property ( // R17
    @(posedge clk) disable iff (sys_rst)
    (csRise && !frameOk && !sleeping) |=> $stable(q.cmdOn))
    else $error("bad length frame changed outputs");

  latch_hold_a: assert property ( // R8
    @(posedge clk) disable iff (sys_rst)
    (!expire && !sleeping) |=>
      (q.faultLatch & $past(q.faultLatch)) == $past(q.faultLatch))
    else $error("fault latch dropped early");

  short_report_a: assert property ( // R11
    @(posedge clk) disable iff (sys_rst)
    !sleeping |=> (q.faultLatch & $past(shortNow)) == $past(shortNow))
    else $error("short fault not latched");

  ol_when_on_a: assert property ( // R1
    @(posedge clk) disable iff (sys_rst)
    (expire && !sleeping) |=>
      ((q.faultLatch & ~$past(q.faultLatch) & ~$past(shortNow)
        & $past(q.cmdOn)) == OSF_ALL_OFF))
    else $error("open load latched on an on output");

  // Reset and power-on state
  rst_out_off_a: assert property ( // R4
    @(posedge clk)
    sys_rst |=> (q.outDrive == OSF_ALL_OFF)
                && (q.detSrc == OSF_ALL_OFF))
    else $error("output or source on after reset");

  rst_state_a: assert property ( // R13
    @(posedge clk)
    sys_rst |=> !q.tmrRun && (q.faultLatch == OSF_ALL_OFF))
    else $error("internal state not cleared by reset");

  cs_idle_a: assert property ( // R7
    @(posedge clk)
    sys_rst |=> q.csSync2 && q.csPrev)
    else $error("chip select flops not at idle level");

  sleep_clear_a: assert property ( // R13
    @(posedge clk) disable iff (sys_rst)
    sleeping |=> (q.faultLatch == OSF_ALL_OFF)
                 && (q.cmdOn == OSF_ALL_OFF) && !q.tmrRun)
    else $error("supply loss left logic state");

  // Detection sources and command word
  src_follow_a: assert property ( // R3
    @(posedge clk) disable iff (sys_rst)
    !sleeping |=> q.detSrc == $past(q.detEn))
    else $error("source does not follow enable");

  no_frame_hold_a: assert property ( // R14
    @(posedge clk) disable iff (sys_rst)
    (!frameOk && !sleeping) |=> $stable(q.cmdOn) && $stable(q.detEn))
    else $error("command changed without a frame");

  read_flag_a: assert property ( // R18
    @(posedge clk) disable iff (sys_rst)
    (frameOk && !sleeping) |=> q.readDone)
    else $error("read flag not set by frame");

  // Open load filter and latch
  tmr_count_a: assert property ( // R6
    @(posedge clk) disable iff (sys_rst)
    (q.tmrRun && !csRise && !expire && !sleeping)
      |=> q.tmr == ($past(q.tmr) + 1'b1))
    else $error("filter timer did not advance");

  expire_once_a: assert property ( // R6
    @(posedge clk) disable iff (sys_rst)
    (expire && !sleeping) |=> !q.tmrRun)
    else $error("filter timer ran past expiry");

  ol_only_expiry_a: assert property ( // R7
    @(posedge clk) disable iff (sys_rst)
    (!expire && !sleeping) |=>
      ((q.faultLatch & ~$past(q.faultLatch) & ~$past(shortNow))
       == OSF_ALL_OFF))
    else $error("open load latched before expiry");

  ol_latch_a: assert property ( // R2
    @(posedge clk) disable iff (sys_rst)
    (expire && !sleeping) |=>
      (q.faultLatch & $past(olNow)) == $past(olNow))
    else $error("open load not latched at expiry");

  ol_disabled_a: assert property ( // R16
    @(posedge clk) disable iff (sys_rst)
    (expire && !sleeping) |=>
      ((q.faultLatch & ~$past(q.faultLatch) & ~$past(shortNow)
        & ~$past(q.detEn)) == OSF_ALL_OFF))
    else $error("open load latched with source disabled");

  clear_unread_a: assert property ( // R18
    @(posedge clk) disable iff (sys_rst)
    (expire && !q.readDone && !sleeping) |=>
      (q.faultLatch & $past(q.faultLatch)) == $past(q.faultLatch))
    else $error("fault cleared before it was read");

  // Status word
  status_load_a: assert property ( // R15
    @(posedge clk) disable iff (sys_rst)
    (q.csSync2 && !sleeping) |=>
      q.statusWord[OSF_CH-1:0] == $past(q.faultLatch))
    else $error("status word not loaded from latch");

  status_frozen_a: assert property ( // R15
    @(posedge clk) disable iff (sys_rst)
    (!q.csSync2 && !sleeping) |=> $stable(q.statusWord))
    else $error("status word changed inside a frame");

  // Thermal cut and retry
  retry_a: assert property ( // R10
    @(posedge clk) disable iff (sys_rst)
    (!sleeping && (q.sense2.thermLim == OSF_ALL_OFF))
      |=> q.outDrive == $past(q.cmdOn))
    else $error("output not restored after cooling");

  cmd_off_a: assert property ( // R10
    @(posedge clk) disable iff (sys_rst)
    !sleeping |=> (q.outDrive & ~$past(q.cmdOn)) == OSF_ALL_OFF)
    else $error("output on while commanded off");

  // Link side reset copy
  link_cnt_rst_a: assert property ( // R17
    @(posedge sclk)
    l.rst2 |=> l.cnt == '0)
    else $error("link counter not cleared by reset");

  link_do_rst_a: assert property ( // R15
    @(posedge sclk)
    l.rst2 |=> !l.doBit)
    else $error("serial output not low after reset");

endmodule

// ===== tb/osf_spi_master.sv
// Serial master model standing in for the controller
`timescale 1ns/100ps
module osf_spi_master (
  // Link pins
  output logic      sclk,
  output logic      csN,
  output logic      mosi,
  input  wire logic doPin
);
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    mosi = 1'b0;
  end

  // Clock pulses with chip select high, only to reset the link side
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
  endtask

  // Send d[n-1:0] MSB first and collect what comes back
  task automatic xfer(input logic [31:0] d, input int n,
                      output logic [31:0] q);
    q = '0;
    csN = 1'b0;
    #60;
    // any n bits as given, short frames sent on purpose
    for (int i = n - 1; i >= 0; i--) begin
      mosi = d[i];
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
      q[i] = doPin;
    end
    #60;
    csN = 1'b1;
    // Released line must not keep the last bit
    mosi = ~mosi;
    #100;
  endtask
endmodule

// ===== tb/tb_osf_fault_logic.sv
// Self-checking bench for the octal switch fault logic
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  failures++; $display("ERROR t=%0t got %0h exp %0h", $time, a, e); \
  end end
module tb_osf_fault_logic import osf_pkg::*; ;
  localparam int FILT = 10000;
  logic        clk = 1'b0;
  logic        sys_rst;
  logic        sclk;
  logic        csN;
  logic        mosi;
  logic        doPin;
  osf_sense_s  sense;
  osf_supply_s supply;
  logic [7:0]  outDrive;
  logic [7:0]  detSrcEn;
  logic [31:0] rd;
  int          failures = 0;
  int          comparisons = 0;
  osf_supply_s sups [3] = '{3'b101, 3'b011, 3'b000};

  always #5 clk = ~clk;

  osf_fault_logic #(.FILT_CYCLES(FILT)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .csN(csN),
    .mosi(mosi), .doPin(doPin), .sense(sense), .supply(supply),
    .outDrive(outDrive), .detSrcEn(detSrcEn));
  osf_spi_master u_mst (
    .sclk(sclk), .csN(csN), .mosi(mosi), .doPin(doPin));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic frame(input logic [31:0] d, input int n, input int w);
    u_mst.xfer(d, n, rd);
    cyc(w);
  endtask

  task automatic give_verdict;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    failures++;
    give_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    sense   = '0;
    supply  = 3'b001;
    fork
      repeat (12) @(posedge clk);
      u_mst.idle_clocks(4);
    join
    sys_rst <= 1'b0;
    cyc(12);
    // Link reset copy needs clocks after release to let go
    u_mst.idle_clocks(2);
    `CHK({detSrcEn, outDrive}, 16'h0000)
    frame(32'hF00F, 16, 20);
    `CHK(rd[15:0], 16'h0000)
    `CHK({detSrcEn, outDrive}, 16'hF00F)
    frame(32'h0FFF, 12, 20);
    `CHK({detSrcEn, outDrive}, 16'hF00F)
    frame(32'hA58001, 24, 20);
    `CHK(rd[23:0], 24'h0000A5)
    `CHK({detSrcEn, outDrive}, 16'h8001)
    // Open load on a watched off output, a disabled one and an on one
    @(posedge clk) sense <= 24'h000091;
    frame(32'h8001, 16, FILT * 6 / 10);
    frame(32'h8001, 16, FILT * 6 / 10);
    `CHK(rd[15:0], 16'h0000)
    frame(32'h8001, 16, FILT + 100);
    `CHK(rd[15:0], 16'h0000)
    frame(32'h8001, 16, 20);
    `CHK(rd[15:0], 16'h0080)
    @(posedge clk) sense <= '0;
    frame(32'h8001, 16, FILT + 100);
    `CHK(rd[15:0], 16'h0080)
    frame(32'h0003, 16, 20);
    `CHK(rd[15:0], 16'h0000)
    @(posedge clk) sense <= 24'h010000;
    cyc(6);
    `CHK(outDrive, 8'h02)
    @(posedge clk) sense <= '0;
    cyc(6);
    `CHK(outDrive, 8'h03)
    frame(32'h0003, 16, 20);
    `CHK(rd[15:0], 16'h0001)
    // Logic undervoltage, load undervoltage, then sleep
    for (int i = 0; i < 3; i++) begin
      frame(32'hF00F, 16, 20);
      @(posedge clk) supply <= sups[i];
      cyc(6);
      `CHK({detSrcEn, outDrive}, 16'h0000)
      @(posedge clk) supply <= 3'b001;
      cyc(12);
      `CHK({detSrcEn, outDrive}, 16'h0000)
    end
    give_verdict();
  end
endmodule
